/* File: seqtrk_consts.vh */
`ifndef SEQTRK_CONSTS_VH
`define SEQTRK_CONSTS_VH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define A_CTRL      8'h00
`define A_CONN_EN   8'h04
`define A_INT_STAT  8'h08
`define A_INT_MASK  8'h0C
`define A_LINK      8'h10
`define A_LOST      8'h14
`define A_LONGEST   8'h18
`define A_DUP       8'h1C
`define A_HIST_BASE 8'h20
`define A_HIST_LAST 8'h34
`define A_OVERFLOW  8'h38
`define A_Q2_DEPTH  8'h3C
`define A_Q1_DEPTH  8'h40
`define A_FILLER    8'h44

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define CTRL_SEL_LSB  0
`define CTRL_SEL_W    5
`define CTRL_CLR_BIT  8
`define CTRL_TCLR_BIT 9

// ----------------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------------
`define IRQ_W       5
`define IRQ_GAP     0
`define IRQ_DUP     1
`define IRQ_OVF     2
`define IRQ_FILL    3
`define IRQ_RESYNC  4

// ----------------------------------------------------------------------
// bundle record layout
// ----------------------------------------------------------------------
`define SEQ_W       16
`define CNT_W       16
`define F_SYNC      0
`define F_LAST      1
`define F_LOST      17
`define F_LONG      33
`define F_DUP       49
`define F_HIST      65
`define HIST_N      6
`define REC_W       161
`define BND_W       5

// ----------------------------------------------------------------------
// sequence tracking constants
// ----------------------------------------------------------------------
`define SEQ_ONE     16'h0001
`define WIN_DEPTH   16'h001E
`define HALF_RANGE  16'h8000
`define HIST_BIG    16'h0005
`define CNT_MAX     16'hFFFF
`define CNT_ZERO    16'h0000

// ----------------------------------------------------------------------
// bundle link states
// ----------------------------------------------------------------------
`define LS_UP       2'h0
`define LS_DISABLED 2'h1
`define LS_WAIT     2'h2
`define LS_NET_DOWN 2'h3

`endif

/* File: seq_state_mem.v */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------
// per-bundle record store: one write port, two registered read ports
// ----------------------------------------------------------------------
module seq_state_mem #(
   parameter W  = 161,
   parameter AW = 5
) (
   input  wire          mclk_i,
   input  wire          we_i,
   input  wire [AW-1:0] waddr_i,
   input  wire [W-1:0]  wdata_i,
   input  wire [AW-1:0] raddr_a_i,
   output reg  [W-1:0]  rdata_a_o,
   input  wire [AW-1:0] raddr_b_i,
   output reg  [W-1:0]  rdata_b_o
);

   reg [W-1:0] mem_reg [0:(1<<AW)-1];

   // read-before-write; caller bypasses same-address hazards
   always @(posedge mclk_i) begin
      if (we_i) begin
         mem_reg[waddr_i] <= wdata_i;
      end
      rdata_a_o <= mem_reg[raddr_a_i];
      rdata_b_o <= mem_reg[raddr_b_i];
   end

endmodule // seq_state_mem

`default_nettype wire

/* File: seq_tracker.v */
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "seqtrk_consts.vh"

// Overview of operation
// - 65535 is followed by 0, and that wrap counts as consecutive
// - every skipped sequence number adds to the lost-packet counter
// - longest single gap of missing numbers is kept and raised when exceeded
// - an already-seen number is dropped and the duplicate counter bumped
// - duplicates are judged only within a 30-packet window, losses within half the number range
// - a number under 30 behind the last one is dropped, state unchanged
// - an older number beyond the window is accepted and resynchronises
// - link state reports up, disabled, waiting or network down
// - connection enable off reports disabled whatever the network does
// - network without transport reports waiting; no network reports down
// - transparent packets discarded on buffer overflow are counted
// - live block counts of both transmit queue stages are readable
// - a missing packet at play-out sends a filler and is counted
// - tracking state and counters kept separately for bundles 1 to 30
// - gap histogram counts gaps of one to five and more than five
module seq_tracker #(
   parameter NB = 30,
   parameter QW = 16
) (
   input  wire                 mclk_i,
   input  wire                 sys_rst_i,
   input  wire                 pkt_valid_i,
   input  wire [`BND_W-1:0]    pkt_bundle_i,
   input  wire [`SEQ_W-1:0]    pkt_seq_i,
   output reg                  pkt_fwd_o,
   output reg                  pkt_drop_o,
   input  wire [NB:1]          net_up_i,
   input  wire [NB:1]          transport_up_i,
   input  wire                 ovf_drop_i,
   input  wire                 q1_push_i,
   input  wire                 q1_pop_i,
   input  wire                 q2_push_i,
   input  wire                 q2_pop_i,
   input  wire                 playout_req_i,
   output reg                  filler_send_o,
   input  wire [7:0]           reg_addr_i,
   input  wire [31:0]          reg_wdata_i,
   input  wire                 reg_wr_i,
   input  wire                 reg_rd_i,
   output reg  [31:0]          reg_rdata_o,
   output reg  [1:0]           link_state_o,
   output reg                  irq_o
);

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function [`CNT_W-1:0] sat_add;
      input [`CNT_W-1:0] a;
      input [`CNT_W-1:0] b;
      reg   [`CNT_W:0]   s;
      begin
         s = {1'b0, a} + {1'b0, b};
         sat_add = s[`CNT_W] ? `CNT_MAX : s[`CNT_W-1:0];
      end
   endfunction

   function [`CNT_W-1:0] sat_inc;
      input [`CNT_W-1:0] a;
      begin
         sat_inc = (a == `CNT_MAX) ? a : a + `SEQ_ONE;
      end
   endfunction

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   reg                 s1_vld_reg;
   reg [`BND_W-1:0]    s1_bnd_reg;
   reg [`SEQ_W-1:0]    s1_seq_reg;
   reg                 pw_vld_reg;
   reg [`BND_W-1:0]    pw_addr_reg;
   reg [`REC_W-1:0]    pw_data_reg;
   reg                 clr_pend_reg;
   reg [`BND_W-1:0]    clr_bnd_reg;
   reg [`BND_W-1:0]    sel_reg;
   reg [NB:1]          conn_en_reg;
   reg [`IRQ_W-1:0]    int_stat_reg;
   reg [`IRQ_W-1:0]    int_mask_reg;
   reg [`CNT_W-1:0]    ovf_cnt_reg;
   reg [`CNT_W-1:0]    fill_cnt_reg;
   reg [QW-1:0]        q1_depth_reg;
   reg [QW-1:0]        q2_depth_reg;

   wire [`REC_W-1:0]   mem_rd_a;
   wire [`REC_W-1:0]   mem_rd_b;
   reg                 mem_we;
   reg [`BND_W-1:0]    mem_waddr;
   reg [`REC_W-1:0]    mem_wdata;

   reg [`REC_W-1:0]    rec_cur;
   reg [`REC_W-1:0]    rec_nx;
   reg [`SEQ_W-1:0]    last_seq;
   reg [`SEQ_W-1:0]    diff;
   reg [`SEQ_W-1:0]    back;
   reg [`SEQ_W-1:0]    gap;
   reg [`SEQ_W-1:0]    hidx;
   reg                 acc;
   reg                 ev_gap;
   reg                 ev_dup;
   reg                 ev_rs;

   wire pkt_in_range = (pkt_bundle_i >= 5'h01) && (pkt_bundle_i <= NB[`BND_W-1:0]);
   wire wr_ctrl      = reg_wr_i && (reg_addr_i == `A_CTRL);
   wire rd_stat      = reg_rd_i && (reg_addr_i == `A_INT_STAT);
   wire filler_now   = playout_req_i && (q1_depth_reg == {QW{1'b0}});

   // ----------------------------------------------------------------------
   // record memory
   // ----------------------------------------------------------------------
   seq_state_mem #(
      .W  (`REC_W),
      .AW (`BND_W)
   ) u_mem (
      .mclk_i    (mclk_i),
      .we_i      (mem_we),
      .waddr_i   (mem_waddr),
      .wdata_i   (mem_wdata),
      .raddr_a_i (pkt_bundle_i),
      .rdata_a_o (mem_rd_a),
      .raddr_b_i (sel_reg),
      .rdata_b_o (mem_rd_b)
   );

   // ----------------------------------------------------------------------
   // sequence analysis of the packet in stage 2
   // ----------------------------------------------------------------------
   always @* begin
      rec_cur = (pw_vld_reg && (pw_addr_reg == s1_bnd_reg)) ? pw_data_reg : mem_rd_a;
      rec_nx  = rec_cur;
      last_seq = rec_cur[`F_LAST +: `SEQ_W];
      diff    = s1_seq_reg - last_seq;
      back    = last_seq - s1_seq_reg;
      gap     = diff - `SEQ_ONE;
      hidx    = (gap > `HIST_BIG) ? `HIST_BIG : gap - `SEQ_ONE;
      acc     = 1'b0;
      ev_gap  = 1'b0;
      ev_dup  = 1'b0;
      ev_rs   = 1'b0;
      if (!rec_cur[`F_SYNC]) begin
         acc = 1'b1;
      end else if (diff == `SEQ_ONE) begin
         acc = 1'b1;
      end else if (back < `WIN_DEPTH) begin
         ev_dup = 1'b1;
         rec_nx[`F_DUP +: `CNT_W] = sat_inc(rec_cur[`F_DUP +: `CNT_W]);
      end else if (diff < `HALF_RANGE) begin
         acc    = 1'b1;
         ev_gap = 1'b1;
         rec_nx[`F_LOST +: `CNT_W] = sat_add(rec_cur[`F_LOST +: `CNT_W], gap);
         if (gap > rec_cur[`F_LONG +: `CNT_W]) begin
            rec_nx[`F_LONG +: `CNT_W] = gap;
         end
         rec_nx[`F_HIST + hidx[2:0]*`CNT_W +: `CNT_W] =
            sat_inc(rec_cur[`F_HIST + hidx[2:0]*`CNT_W +: `CNT_W]);
      end else begin
         acc   = 1'b1;
         ev_rs = 1'b1;
      end
      if (acc) begin
         rec_nx[`F_SYNC] = 1'b1;
         rec_nx[`F_LAST +: `SEQ_W] = s1_seq_reg;
      end
   end

   // ----------------------------------------------------------------------
   // memory write select: packet update first, pending clear otherwise
   // ----------------------------------------------------------------------
   always @* begin
      mem_we    = 1'b0;
      mem_waddr = s1_bnd_reg;
      mem_wdata = rec_nx;
      if (s1_vld_reg) begin
         mem_we = 1'b1;
      end else if (clr_pend_reg) begin
         mem_we    = 1'b1;
         mem_waddr = clr_bnd_reg;
         mem_wdata = {`REC_W{1'b0}};
      end
   end

   // ----------------------------------------------------------------------
   // packet pipeline and bypass
   // ----------------------------------------------------------------------
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         s1_vld_reg  <= 1'b0;
         s1_bnd_reg  <= {`BND_W{1'b0}};
         s1_seq_reg  <= {`SEQ_W{1'b0}};
         pw_vld_reg  <= 1'b0;
         pw_addr_reg <= {`BND_W{1'b0}};
         pw_data_reg <= {`REC_W{1'b0}};
         pkt_fwd_o   <= 1'b0;
         pkt_drop_o  <= 1'b0;
      end else begin
         s1_vld_reg  <= pkt_valid_i && pkt_in_range;
         s1_bnd_reg  <= pkt_bundle_i;
         s1_seq_reg  <= pkt_seq_i;
         pw_vld_reg  <= mem_we;
         pw_addr_reg <= mem_waddr;
         pw_data_reg <= mem_wdata;
         pkt_fwd_o   <= s1_vld_reg && acc;
         pkt_drop_o  <= s1_vld_reg && !acc;
      end
   end

   // ----------------------------------------------------------------------
   // control, clear command and connection enables
   // ----------------------------------------------------------------------
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         sel_reg      <= 5'h01;
         conn_en_reg  <= {NB{1'b0}};
         int_mask_reg <= {`IRQ_W{1'b0}};
         clr_pend_reg <= 1'b0;
         clr_bnd_reg  <= {`BND_W{1'b0}};
      end else begin
         if (wr_ctrl) begin
            sel_reg <= reg_wdata_i[`CTRL_SEL_LSB +: `CTRL_SEL_W];
         end
         if (reg_wr_i && (reg_addr_i == `A_CONN_EN)) begin
            conn_en_reg <= reg_wdata_i[NB-1:0];
         end
         if (reg_wr_i && (reg_addr_i == `A_INT_MASK)) begin
            int_mask_reg <= reg_wdata_i[`IRQ_W-1:0];
         end
         if (wr_ctrl && reg_wdata_i[`CTRL_CLR_BIT]) begin
            clr_pend_reg <= 1'b1;
            clr_bnd_reg  <= reg_wdata_i[`CTRL_SEL_LSB +: `CTRL_SEL_W];
         end else if (!s1_vld_reg) begin
            clr_pend_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // transparent channel counters and queue depths
   // ----------------------------------------------------------------------
   wire tclr = wr_ctrl && reg_wdata_i[`CTRL_TCLR_BIT];

   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         ovf_cnt_reg   <= `CNT_ZERO;
         fill_cnt_reg  <= `CNT_ZERO;
         q1_depth_reg  <= {QW{1'b0}};
         q2_depth_reg  <= {QW{1'b0}};
         filler_send_o <= 1'b0;
      end else begin
         if (ovf_drop_i) begin
            ovf_cnt_reg <= tclr ? `SEQ_ONE : sat_inc(ovf_cnt_reg);
         end else if (tclr) begin
            ovf_cnt_reg <= `CNT_ZERO;
         end
         if (filler_now) begin
            fill_cnt_reg <= tclr ? `SEQ_ONE : sat_inc(fill_cnt_reg);
         end else if (tclr) begin
            fill_cnt_reg <= `CNT_ZERO;
         end
         filler_send_o <= filler_now;
         if (q1_push_i && !q1_pop_i && (q1_depth_reg != {QW{1'b1}})) begin
            q1_depth_reg <= q1_depth_reg + {{(QW-1){1'b0}}, 1'b1};
         end else if (q1_pop_i && !q1_push_i && (q1_depth_reg != {QW{1'b0}})) begin
            q1_depth_reg <= q1_depth_reg - {{(QW-1){1'b0}}, 1'b1};
         end
         if (q2_push_i && !q2_pop_i && (q2_depth_reg != {QW{1'b1}})) begin
            q2_depth_reg <= q2_depth_reg + {{(QW-1){1'b0}}, 1'b1};
         end else if (q2_pop_i && !q2_push_i && (q2_depth_reg != {QW{1'b0}})) begin
            q2_depth_reg <= q2_depth_reg - {{(QW-1){1'b0}}, 1'b1};
         end
      end
   end

   // ----------------------------------------------------------------------
   // link state of the selected bundle
   // ----------------------------------------------------------------------
   reg [1:0] link_next;
   wire sel_ok = (sel_reg >= 5'h01) && (sel_reg <= NB[`BND_W-1:0]);

   always @* begin
      link_next = `LS_DISABLED;
      if (!sel_ok || !conn_en_reg[sel_reg]) begin
         link_next = `LS_DISABLED;
      end else if (!net_up_i[sel_reg]) begin
         link_next = `LS_NET_DOWN;
      end else if (!transport_up_i[sel_reg]) begin
         link_next = `LS_WAIT;
      end else begin
         link_next = `LS_UP;
      end
   end

   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         link_state_o <= `LS_DISABLED;
      end else begin
         link_state_o <= link_next;
      end
   end

   // ----------------------------------------------------------------------
   // interrupts: sticky, cleared by read, set wins
   // ----------------------------------------------------------------------
   wire [`IRQ_W-1:0] ev_vec = {s1_vld_reg && ev_rs, filler_now, ovf_drop_i,
                               s1_vld_reg && ev_dup, s1_vld_reg && ev_gap};
   wire [`IRQ_W-1:0] int_stat_next = (rd_stat ? {`IRQ_W{1'b0}} : int_stat_reg) | ev_vec;

   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         int_stat_reg <= {`IRQ_W{1'b0}};
         irq_o        <= 1'b0;
      end else begin
         int_stat_reg <= int_stat_next;
         irq_o        <= |(int_stat_next & int_mask_reg);
      end
   end

   // ----------------------------------------------------------------------
   // register read port
   // ----------------------------------------------------------------------
   reg [31:0] rd_next;
   reg [7:0]  hoff;

   always @* begin
      rd_next = 32'h0000_0000;
      hoff    = reg_addr_i - `A_HIST_BASE;
      case (reg_addr_i)
         `A_CTRL:     rd_next[`CTRL_SEL_LSB +: `CTRL_SEL_W] = sel_reg;
         `A_CONN_EN:  rd_next[NB-1:0] = conn_en_reg;
         `A_INT_STAT: rd_next[`IRQ_W-1:0] = int_stat_reg;
         `A_INT_MASK: rd_next[`IRQ_W-1:0] = int_mask_reg;
         `A_LINK:     rd_next[1:0] = link_state_o;
         `A_LOST:     rd_next[`CNT_W-1:0] = mem_rd_b[`F_LOST +: `CNT_W];
         `A_LONGEST:  rd_next[`CNT_W-1:0] = mem_rd_b[`F_LONG +: `CNT_W];
         `A_DUP:      rd_next[`CNT_W-1:0] = mem_rd_b[`F_DUP +: `CNT_W];
         `A_OVERFLOW: rd_next[`CNT_W-1:0] = ovf_cnt_reg;
         `A_Q2_DEPTH: rd_next[QW-1:0] = q2_depth_reg;
         `A_Q1_DEPTH: rd_next[QW-1:0] = q1_depth_reg;
         `A_FILLER:   rd_next[`CNT_W-1:0] = fill_cnt_reg;
         default: begin
            if ((reg_addr_i >= `A_HIST_BASE) && (reg_addr_i <= `A_HIST_LAST) &&
                (reg_addr_i[1:0] == 2'h0)) begin
               rd_next[`CNT_W-1:0] = mem_rd_b[`F_HIST + hoff[4:2]*`CNT_W +: `CNT_W];
            end
         end
      endcase
      if (!sel_ok && (reg_addr_i >= `A_LOST) && (reg_addr_i <= `A_HIST_LAST)) begin
         rd_next = 32'h0000_0000;
      end
   end

   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else begin
         reg_rdata_o <= reg_rd_i ? rd_next : 32'h0000_0000;
      end
   end

endmodule // seq_tracker

`default_nettype wire

/* File: seq_tracker_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
`include "seqtrk_consts.vh"

module seq_tracker_monitor (
   input wire logic              mclk_i,
   input wire logic              sys_rst_i,
   input wire logic              pkt_valid_i,
   input wire logic [`BND_W-1:0] pkt_bundle_i,
   input wire logic              pkt_fwd_o,
   input wire logic              pkt_drop_o,
   input wire logic              ovf_drop_i,
   input wire logic              playout_req_i,
   input wire logic              filler_send_o,
   input wire logic              reg_wr_i,
   input wire logic              reg_rd_i,
   input wire logic [31:0]       reg_rdata_o,
   input wire logic [1:0]        link_state_o,
   input wire logic              irq_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   wire logic in_rng = (pkt_bundle_i != 5'h00) && (pkt_bundle_i != 5'h1F);

   // ----------------------------------------------------------------
   // packet path
   // ----------------------------------------------------------------
   sequence s_take;
      pkt_valid_i && in_rng;
   endsequence
   sequence s_answer;
      ##2 (pkt_fwd_o ^ pkt_drop_o);
   endsequence
   property p_one_answer;
      s_take |-> s_answer;
   endproperty
   a_one_answer: assert property (p_one_answer) else $error("no single answer to packet");
   property p_ignored;
      pkt_valid_i && !in_rng |-> ##2 !(pkt_fwd_o || pkt_drop_o);
   endproperty
   a_ignored: assert property (p_ignored) else $error("answer to ignored bundle");
   property p_fwd_cause;
      pkt_fwd_o |-> $past(pkt_valid_i, 2);
   endproperty
   a_fwd_cause: assert property (p_fwd_cause) else $error("forward without packet");
   property p_drop_cause;
      pkt_drop_o |-> $past(pkt_valid_i, 2) && !pkt_fwd_o;
   endproperty
   a_drop_cause: assert property (p_drop_cause) else $error("drop without packet");
   property p_filler_cause;
      filler_send_o |-> $past(playout_req_i);
   endproperty
   a_filler_cause: assert property (p_filler_cause) else $error("filler without play-out");

   // ----------------------------------------------------------------
   // register port and interrupt
   // ----------------------------------------------------------------
   property p_rdata_idle;
      !$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
   property p_irq_rise;
      $rose(irq_o) |-> pkt_fwd_o || pkt_drop_o || filler_send_o || $past(ovf_drop_i)
         || $past(ovf_drop_i, 2) || $past(reg_wr_i) || $past(reg_wr_i, 2);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("interrupt without event");
   property p_irq_fall;
      $fell(irq_o) |-> $past(reg_rd_i) || $past(reg_rd_i, 2) || $past(reg_wr_i)
         || $past(reg_wr_i, 2);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped by itself");
   property p_reset_link;
      $fell(sys_rst_i) |-> link_state_o == `LS_DISABLED && !irq_o;
   endproperty
   a_reset_link: assert property (p_reset_link) else $error("link state after reset");
endmodule // seq_tracker_monitor

bind seq_tracker seq_tracker_monitor seq_tracker_monitor_i (
   .mclk_i, .sys_rst_i, .pkt_valid_i, .pkt_bundle_i, .pkt_fwd_o, .pkt_drop_o, .ovf_drop_i,
   .playout_req_i, .filler_send_o, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .link_state_o, .irq_o
);

`default_nettype wire

/* File: remote_sender.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// far gateway: stamps packets, skip offset makes gaps or repeats
// ----------------------------------------------------------------
module remote_sender (
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        go_i,
   input  wire logic [4:0]  bnd_i,
   input  wire logic [15:0] sk_i,
   input  wire logic        load_i,
   input  wire logic [15:0] load_val_i,
   output wire logic        pkt_valid_o,
   output wire logic [4:0]  pkt_bundle_o,
   output wire logic [15:0] pkt_seq_o
);
   logic [15:0] next_reg;
   wire  logic [15:0] cur;
   assign cur = next_reg + sk_i;
   assign pkt_valid_o = go_i;
   // released lines show the inverse, not the last value
   assign pkt_seq_o = go_i ? cur : ~cur;
   assign pkt_bundle_o = go_i ? bnd_i : ~bnd_i;
   always @(posedge mclk_i) begin
      if (sys_rst_i)
         next_reg <= 16'h0000;
      else if (load_i)
         next_reg <= load_val_i;
      else if (go_i && !sk_i[15])
         next_reg <= cur + 16'h0001;
   end
endmodule // remote_sender

`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "seqtrk_consts.vh"

module testbench;
   logic        mclk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        go = 1'b0;
   logic [4:0]  bnd = 5'h01;
   logic [15:0] sk = 16'h0000;
   logic        ld = 1'b0;
   logic [15:0] ld_val = 16'h0000;
   logic [5:0]  ev = 6'h00;
   logic [30:1] net_up = 30'h0000_0000;
   logic [30:1] trans_up = 30'h0000_0000;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   wire  logic        pv, fwd, drop, fill, irq;
   wire  logic [4:0]  pb;
   wire  logic [15:0] ps;
   wire  logic [31:0] rdata;
   wire  logic [1:0]  link;
   logic [31:0] d;
   int          fails = 0, comparisons = 0;

   always #10 mclk_i = ~mclk_i;

   remote_sender remote_sender_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .go_i(go),
      .bnd_i(bnd), .sk_i(sk), .load_i(ld), .load_val_i(ld_val), .pkt_valid_o(pv),
      .pkt_bundle_o(pb), .pkt_seq_o(ps));

   seq_tracker seq_tracker_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .pkt_valid_i(pv),
      .pkt_bundle_i(pb), .pkt_seq_i(ps), .pkt_fwd_o(fwd), .pkt_drop_o(drop),
      .net_up_i(net_up), .transport_up_i(trans_up), .ovf_drop_i(ev[0]), .q1_push_i(ev[1]),
      .q1_pop_i(ev[2]), .q2_push_i(ev[3]), .q2_pop_i(ev[4]), .playout_req_i(ev[5]),
      .filler_send_o(fill), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .link_state_o(link), .irq_o(irq));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk_i);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge mclk_i);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge mclk_i);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk_i);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task stat(input logic [4:0] b, input logic [7:0] a, input logic [31:0] exp);
      wr_reg(`A_CTRL, {27'h000_0000, b});
      rd_reg(a, d);
      chk(d, exp);
   endtask
   task snd(input logic [4:0] b, input logic [15:0] s, input logic [1:0] e);
      @(posedge mclk_i);
      go <= 1'b1;
      bnd <= b;
      sk <= s;
      @(posedge mclk_i);
      go <= 1'b0;
      @(posedge mclk_i);
      #1 chk({drop, fwd}, e);
   endtask
   task load(input logic [15:0] v);
      @(posedge mclk_i);
      ld <= 1'b1;
      ld_val <= v;
      @(posedge mclk_i);
      ld <= 1'b0;
   endtask
   task pulse(input logic [5:0] p);
      @(posedge mclk_i);
      ev <= p;
      @(posedge mclk_i);
      ev <= 6'h00;
   endtask
   task link_case(input logic en, input logic nt, input logic tr, input logic [1:0] e);
      wr_reg(`A_CONN_EN, en ? 32'h0000_0004 : 32'h0000_0000);
      net_up[3] <= nt;
      trans_up[3] <= tr;
      repeat (3) @(posedge mclk_i);
      #1 chk(link, e);
      rd_reg(`A_LINK, d);
      chk(d, {30'h0000_0000, e});
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_reset;
      logic [4:0] b;
      chk(link, `LS_DISABLED);
      rd_reg(`A_INT_MASK, d);
      chk(d, 32'h0000_0000);
      rd_reg(8'h48, d);
      chk(d, 32'h0000_0000);
      rd_reg(8'h02, d);
      chk(d, 32'h0000_0000);
      for (b = 5'h01; b != 5'h1F; b++)
         wr_reg(`A_CTRL, {23'h00_0000, 4'h8, b});
      $display("test reset done");
   endtask
   task t_seq;
      load(16'hFFFE);
      repeat (3) snd(5'h01, 16'h0000, 2'h1);
      snd(5'h01, 16'h0003, 2'h1);
      snd(5'h01, 16'h0001, 2'h1);
      snd(5'h01, 16'h0007, 2'h1);
      chk(irq, 1'b0);
      stat(5'h01, `A_LOST, 32'h0000_000B);
      stat(5'h01, `A_LONGEST, 32'h0000_0007);
      stat(5'h01, `A_HIST_BASE, 32'h0000_0001);
      stat(5'h01, 8'h24, 32'h0000_0000);
      stat(5'h01, 8'h28, 32'h0000_0001);
      stat(5'h01, `A_HIST_LAST, 32'h0000_0001);
      $display("test sequence done");
   endtask
   task t_dup;
      wr_reg(`A_INT_MASK, 32'h0000_0002);
      load(16'h0060);
      repeat (5) snd(5'h02, 16'h0000, 2'h1);
      snd(5'h02, 16'hFFE6, 2'h2);
      chk(irq, 1'b1);
      snd(5'h02, 16'h0000, 2'h1);
      snd(5'h02, 16'hFFE2, 2'h2);
      snd(5'h02, 16'hFFE1, 2'h1);
      load(16'h0048);
      snd(5'h02, 16'h0000, 2'h1);
      snd(5'h02, 16'h0023, 2'h1);
      stat(5'h02, `A_DUP, 32'h0000_0002);
      stat(5'h02, `A_LOST, 32'h0000_0023);
      stat(5'h02, `A_LONGEST, 32'h0000_0023);
      rd_reg(`A_INT_STAT, d);
      chk(d[1], 1'b1);
      repeat (2) @(posedge mclk_i);
      #1 chk(irq, 1'b0);
      rd_reg(`A_INT_STAT, d);
      chk(d[1], 1'b0);
      wr_reg(`A_INT_MASK, 32'h0000_0000);
      $display("test duplicate done");
   endtask
   task t_bnd;
      snd(5'h00, 16'h0000, 2'h0);
      snd(5'h1F, 16'h0000, 2'h0);
      load(16'h01F4);
      snd(5'h1E, 16'h0000, 2'h1);
      snd(5'h1E, 16'h0004, 2'h1);
      stat(5'h1E, `A_LOST, 32'h0000_0004);
      repeat (3) snd(5'h1E, 16'h7000, 2'h1);
      stat(5'h1E, `A_LOST, 32'h0000_FFFF);
      stat(5'h01, `A_LOST, 32'h0000_000B);
      $display("test bundles done");
   endtask
   task t_link;
      wr_reg(`A_CTRL, 32'h0000_0003);
      link_case(1'b0, 1'b1, 1'b1, `LS_DISABLED);
      link_case(1'b1, 1'b1, 1'b1, `LS_UP);
      link_case(1'b1, 1'b1, 1'b0, `LS_WAIT);
      link_case(1'b1, 1'b0, 1'b1, `LS_NET_DOWN);
      link_case(1'b0, 1'b0, 1'b0, `LS_DISABLED);
      $display("test link done");
   endtask
   task t_transp;
      repeat (3) pulse(6'h0B);
      pulse(6'h14);
      pulse(6'h06);
      stat(5'h01, `A_OVERFLOW, 32'h0000_0003);
      stat(5'h01, `A_Q1_DEPTH, 32'h0000_0002);
      stat(5'h01, `A_Q2_DEPTH, 32'h0000_0002);
      pulse(6'h20);
      #1 chk(fill, 1'b0);
      repeat (2) pulse(6'h04);
      pulse(6'h20);
      #1 chk(fill, 1'b1);
      stat(5'h01, `A_FILLER, 32'h0000_0001);
      wr_reg(`A_CTRL, 32'h0000_0201);
      stat(5'h01, `A_OVERFLOW, 32'h0000_0000);
      stat(5'h01, `A_FILLER, 32'h0000_0000);
      $display("test transparent done");
   endtask

   // ----------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------
   task final_report;
      $display("comparisons %0d, fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk_i);
      fails++;
      final_report();
   end

   initial begin
      repeat (4) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      t_reset();
      t_seq();
      t_dup();
      t_bnd();
      t_link();
      t_transp();
      final_report();
   end
endmodule // testbench

`default_nettype wire
